/* File: design/ise_core.sv */
// subset instruction decoder and executor with file memory, stack and watchdog
`timescale 1ns/1ps
module ise_core (
  input  wire logic                               clk_sys,         // core instruction clock
  input  wire logic                               resetn,          // async reset, active low
  input  wire logic [ise_pkg::INSN_W-1:0]         insn,            // fetched word at fetch_pc
  input  wire logic [4:0]                         program_counter_high_latch, // upper pc source
  input  wire logic                               wake,            // leaves sleep
  input  wire logic                               file_wr_en,      // external file write
  input  wire logic [ise_pkg::FADDR_W-1:0]        file_wr_addr,    // external write address
  input  wire logic [ise_pkg::DATA_W-1:0]         file_wr_data,    // external write data
  input  wire logic [ise_pkg::FADDR_W-1:0]        file_rd_addr,    // observation address
  output logic      [ise_pkg::PC_W-1:0]           fetch_pc,        // program memory address
  output logic      [ise_pkg::DATA_W-1:0]         w_reg,           // working register
  output ise_pkg::ise_flags_t                     flags,           // status flags
  output logic      [ise_pkg::PC_W-1:0]           top_of_stack,    // last pushed address
  output logic      [ise_pkg::DATA_W-1:0]         file_rd_data,    // registered file read
  output logic      [7:0]                         watchdog_counter, // watchdog count
  output logic      [7:0]                         wdt_prescaler,   // watchdog prescaler
  output logic                                    sleeping,        // oscillator halted
  output logic                                    flushing         // nop cycle in progress
);

  typedef enum {ISE_EXEC, ISE_FLUSH, ISE_SLEEP} ise_state_t;

  ise_state_t                     state;
  logic [ise_pkg::PC_W-1:0]       pc;
  logic [ise_pkg::DATA_W-1:0]     fmem [0:(1<<ise_pkg::FADDR_W)-1];
  logic [ise_pkg::PC_W-1:0]       stack [0:ise_pkg::STACK_DEPTH-1];
  logic [ise_pkg::SP_W-1:0]       sp;

  logic [ise_pkg::FADDR_W-1:0]    f_addr;
  logic [ise_pkg::DATA_W-1:0]     f_val;
  logic [ise_pkg::DATA_W-1:0]     lit;
  logic                           d_sel;
  logic [2:0]                     bsel;
  logic                           exec;
  logic                           is_skip, is_call, is_clear_file_register, is_rrf, is_sleep;
  logic                           is_sub, is_xorl, is_xorf;
  logic [8:0]                     sub_full;
  logic [4:0]                     sub_low;
  logic [ise_pkg::DATA_W-1:0]     next_result;
  logic                           skip_taken;
  ise_pkg::ise_fwrite_t           next_fw;
  logic [ise_pkg::PC_W-1:0]       next_pc;

  function automatic logic zero_of(input logic [ise_pkg::DATA_W-1:0] v);
    zero_of = (v == 8'h00);
  endfunction

  assign exec     = (state == ISE_EXEC);
  assign f_addr   = insn[ise_pkg::FADDR_W-1:0];
  assign f_val    = fmem[f_addr];
  assign lit      = insn[ise_pkg::DATA_W-1:0];
  assign d_sel    = insn[ise_pkg::D_BIT];
  assign bsel     = insn[ise_pkg::BSEL_LSB+2:ise_pkg::BSEL_LSB];
  assign is_skip  = insn[13:10] == ise_pkg::OP_SKIP_SET;
  assign is_call  = insn[13:11] == ise_pkg::OP_CALL;
  assign is_clear_file_register  = insn[13:7] == ise_pkg::OP_CLEAR_FILE_REGISTER;
  assign is_rrf   = insn[13:8] == ise_pkg::OP_RRF;
  assign is_sleep = insn == ise_pkg::OP_SLEEP;
  assign is_sub   = insn[13:9] == ise_pkg::OP_SUBLIT;
  assign is_xorl  = insn[13:8] == ise_pkg::OP_XORLIT;
  assign is_xorf  = insn[13:8] == ise_pkg::OP_XORFILE;
  assign skip_taken = exec && is_skip && f_val[bsel];
  assign sub_full = {1'b0, lit} + {1'b0, ~w_reg} + 9'h001;
  assign sub_low  = {1'b0, lit[3:0]} + {1'b0, ~w_reg[3:0]} + 5'h01;

  always_comb
  begin
    next_result = 8'h00;
    if (is_rrf)
      next_result = {flags.carry, f_val[7:1]};
    else if (is_sub)
      next_result = sub_full[7:0];
    else if (is_xorl)
      next_result = w_reg ^ lit;
    else if (is_xorf)
      next_result = w_reg ^ f_val;
  end

  always_comb
  begin
    next_fw = '0;
    if (exec && is_clear_file_register)
      next_fw = '{1'b1, f_addr, 8'h00};
    else if (exec && (is_rrf || is_xorf) && d_sel)
      next_fw = '{1'b1, f_addr, next_result};
    else if (file_wr_en)
      next_fw = '{1'b1, file_wr_addr, file_wr_data};
  end

  // sequencing: taken skip and call both spend a flushed nop cycle
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      state <= ISE_EXEC;
    else
      case (state)
        ISE_EXEC:
          if (is_sleep)
            state <= ISE_SLEEP;
          else if (skip_taken || is_call)
            state <= ISE_FLUSH;
        ISE_FLUSH: state <= ISE_EXEC;
        ISE_SLEEP:
          if (wake)
            state <= ISE_EXEC;
        default:   state <= ISE_EXEC;
      endcase
  end

  // pc is the address of the word on insn; flush and sleep cycles hold it
  always_comb
  begin
    next_pc = pc;
    case (state)
      ISE_EXEC:
        if (is_call)
          next_pc = {program_counter_high_latch[ise_pkg::HL_LSB+1:ise_pkg::HL_LSB],
                     insn[10:0]};
        else if (skip_taken)
          next_pc = pc + 13'h0002;
        else
          next_pc = pc + 13'h0001;
      default: next_pc = pc;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      pc <= ise_pkg::PC_RST;
    else
      pc <= next_pc;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      sp <= '0;
    else if (exec && is_call)
      sp <= sp + 3'h1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (exec && is_call)
      stack[sp] <= pc + 13'h0001;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      top_of_stack <= ise_pkg::PC_RST;
    else if (exec && is_call)
      top_of_stack <= pc + 13'h0001;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      w_reg <= ise_pkg::W_RST;
    else if (exec && (is_sub || is_xorl || ((is_rrf || is_xorf) && !d_sel)))
      w_reg <= next_result;
  end

  always_ff @(posedge clk_sys)
  begin
    if (next_fw.we)
      fmem[next_fw.addr] <= next_fw.data;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      flags <= ise_pkg::FLAGS_RST;
    else if (exec)
    begin
      if (is_clear_file_register)
        flags.zero <= 1'b1;
      if (is_rrf)
        flags.carry <= f_val[0];
      if (is_sub)
      begin
        flags.carry       <= sub_full[8];
        flags.digit_carry <= sub_low[4];
        flags.zero        <= zero_of(next_result);
      end
      if (is_xorl || is_xorf)
        flags.zero <= zero_of(next_result);
      if (is_sleep)
      begin
        flags.power_down_flag <= 1'b0;
        flags.timeout_flag    <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      watchdog_counter <= ise_pkg::WDT_RST;
      wdt_prescaler    <= ise_pkg::WDT_RST;
    end
    else if (exec && is_sleep)
    begin
      watchdog_counter <= ise_pkg::WDT_RST;
      wdt_prescaler    <= ise_pkg::WDT_RST;
    end
    else if (!sleeping)
    begin
      wdt_prescaler <= wdt_prescaler + 8'h01;
      if (wdt_prescaler == 8'hFF)
        watchdog_counter <= watchdog_counter + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      fetch_pc     <= ise_pkg::PC_RST;
      file_rd_data <= 8'h00;
      sleeping     <= 1'b0;
      flushing     <= 1'b0;
    end
    else
    begin
      fetch_pc     <= next_pc;
      file_rd_data <= fmem[file_rd_addr];
      sleeping     <= (exec && is_sleep) || (state == ISE_SLEEP && !wake);
      flushing     <= exec && (skip_taken || is_call);
    end
  end

  sequence call_issue_s;
    exec && is_call;
  endsequence

  skip_flush_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    skip_taken |=> state == ISE_FLUSH ##1 state == ISE_EXEC)
    else $error("taken skip did not spend one flush cycle");
  call_target_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    call_issue_s |=> pc == {$past(program_counter_high_latch[4:3]), $past(insn[10:0])})
    else $error("call target wrong");
  call_push_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    call_issue_s |=> top_of_stack == $past(pc) + 13'h0001)
    else $error("call return address wrong");
  sub_carry_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    exec && is_sub |=> flags.carry == ($past(lit) >= $past(w_reg)))
    else $error("subtract carry wrong");
  sleep_flags_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    exec && is_sleep |=> !flags.power_down_flag && flags.timeout_flag && sleeping)
    else $error("sleep flags wrong");
  sleep_wdt_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    exec && is_sleep |=> watchdog_counter == 8'h00 && wdt_prescaler == 8'h00)
    else $error("sleep did not clear watchdog");
  xorl_result_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    exec && is_xorl |=> w_reg == ($past(w_reg) ^ $past(lit)) && flags.zero == (w_reg == 8'h00))
    else $error("xor literal wrong");
  clear_file_register_zero_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    exec && is_clear_file_register |=> flags.zero && fmem[$past(f_addr)] == 8'h00)
    else $error("clear file wrong");
endmodule

/* File: shared/ise_pkg.sv */
// package: opcode patterns, field positions, widths and reset values for the subset core
package ise_pkg;
  localparam int INSN_W      = 14;
  localparam int PC_W        = 13;
  localparam int DATA_W      = 8;
  localparam int FADDR_W     = 7;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W        = 3;
  // opcode fields
  localparam logic [3:0] OP_SKIP_SET   = 4'h7;   // 01 11bb : bits 13:10
  localparam logic [2:0] OP_CALL       = 3'h4;   // 10 0 : bits 13:11
  localparam logic [6:0] OP_CLEAR_FILE_REGISTER       = 7'h03;  // 00 0001 1 : bits 13:7
  localparam logic [5:0] OP_RRF        = 6'h0C;  // 00 1100 : bits 13:8
  localparam logic [13:0] OP_SLEEP     = 14'h0063;
  localparam logic [4:0] OP_SUBLIT     = 5'h1E;  // 11 110x : bits 13:9
  localparam logic [5:0] OP_XORLIT     = 6'h3A;  // 11 1010 : bits 13:8
  localparam logic [5:0] OP_XORFILE    = 6'h06;  // 00 0110 : bits 13:8
  localparam int D_BIT    = 7;
  localparam int BSEL_LSB = 7;
  localparam int HL_LSB   = 3;
  // reset values
  localparam logic [PC_W-1:0]   PC_RST   = 13'h0000;
  localparam logic [DATA_W-1:0] W_RST    = 8'h00;
  localparam logic [4:0]        HL_RST   = 5'h00;
  localparam logic [7:0]        WDT_RST  = 8'h00;

  typedef struct packed {
    logic carry;
    logic digit_carry;
    logic zero;
    logic power_down_flag;
    logic timeout_flag;
  } ise_flags_t;

  localparam ise_flags_t FLAGS_RST = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

  typedef struct packed {
    logic                 we;
    logic [FADDR_W-1:0]   addr;
    logic [DATA_W-1:0]    data;
  } ise_fwrite_t;
endpackage

/* File: verification/ise_prog_mem.sv */
// program memory model feeding instruction words to the core
`timescale 1ns/1ps
module ise_prog_mem (
  input  wire logic [ise_pkg::PC_W-1:0]   fetch_pc, // word address
  output logic      [ise_pkg::INSN_W-1:0] insn      // word at that address
);
  logic [ise_pkg::INSN_W-1:0] mem [0:8191];
  // unwritten words read as nop, never unknown
  initial
  begin
    for (int i = 0; i < 8192; i++)
      mem[i] = 14'h0000;
  end
  assign insn = mem[fetch_pc];
endmodule

/* File: verification/test_cpu_instruction_subset_exec.sv */
// self-checking bench: fixed instruction programs with random operands run on the subset core
`timescale 1ns/1ps
`define CHK(g, e) chk(16'(g), 16'(e))
module test_cpu_instruction_subset_exec;
  logic                        clk_sys      = 1'b0;
  logic                        resetn       = 1'b0;
  logic                        wake         = 1'b0;
  logic                        file_wr_en   = 1'b0;
  logic [6:0]                  file_wr_addr = 7'h00;
  logic [7:0]                  file_wr_data = 8'h00;
  logic [6:0]                  file_rd_addr = 7'h00;
  logic [4:0]                  hl           = 5'h00;
  logic [13:0]                 insn;
  logic [12:0]                 fetch_pc, top_of_stack, base;
  logic [7:0]                  w_reg, file_rd_data, wdc, wdp;
  logic                        sleeping, fl, fl0;
  ise_pkg::ise_flags_t         flags;
  logic [7:0]                  a, k, v, u, s, r, x, w, fe, f21, rr;
  logic [4:0]                  h;
  logic [2:0]                  b;
  logic                        d0, d1, c, dc, z;
  int                          miscompares  = 0;
  int                          total_checks = 0;
  int                          cycles       = 0;

  ise_prog_mem prog (.fetch_pc(fetch_pc), .insn(insn));
  ise_core dut (
    .clk_sys(clk_sys), .resetn(resetn), .insn(insn), .program_counter_high_latch(hl),
    .wake(wake), .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr),
    .file_wr_data(file_wr_data), .file_rd_addr(file_rd_addr), .fetch_pc(fetch_pc),
    .w_reg(w_reg), .flags(flags), .top_of_stack(top_of_stack), .file_rd_data(file_rd_data),
    .watchdog_counter(wdc), .wdt_prescaler(wdp), .sleeping(sleeping), .flushing(fl)
  );

  always #20 clk_sys = ~clk_sys;

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // both spin slots call the target; target 0 keeps the core in the spin loop, any other target lets it leave
  task automatic spin(input logic [10:0] t);
    prog.mem[0] = {ise_pkg::OP_CALL, t};
    prog.mem[{hl[4:3], 11'h000}] = {ise_pkg::OP_CALL, t};
  endtask

  task automatic do_reset(input logic [4:0] nh);
    @(negedge clk_sys);
    resetn = 1'b0;
    hl = nh;
    spin(11'h000);
    repeat (6) @(negedge clk_sys);
    resetn = 1'b1;
  endtask

  task automatic fwr(input logic [6:0] ad, input logic [7:0] d);
    @(negedge clk_sys);
    file_wr_en = 1'b1;
    file_wr_addr = ad;
    file_wr_data = d;
    @(negedge clk_sys);
    file_wr_en = 1'b0;
  endtask

  task automatic frd(input logic [6:0] ad, input logic [7:0] e);
    @(negedge clk_sys);
    file_rd_addr = ad;
    repeat (2) @(negedge clk_sys);
    `CHK(file_rd_data, e);
  endtask

  initial
  begin
    void'($urandom(42));
    for (int i = 0; i < 40; i++)
    begin
      h = 5'($urandom);
      {a, k, v, u, s} = 40'({$urandom, $urandom});
      {b, d0, d1} = 5'($urandom);
      if (i == 0)
        k = a;
      if (i == 1)
        {a, k} = 16'h0100;
      base = {h[4:3], 11'h010};
      do_reset(h);
      prog.mem[base] = {ise_pkg::OP_XORLIT, a};
      prog.mem[base + 1] = {ise_pkg::OP_SUBLIT, 1'b0, k};
      prog.mem[base + 2] = {ise_pkg::OP_XORFILE, d0, 7'h20};
      prog.mem[base + 3] = {ise_pkg::OP_RRF, d1, 7'h21};
      prog.mem[base + 4] = {ise_pkg::OP_CLEAR_FILE_REGISTER, 7'h23};
      prog.mem[base + 5] = {ise_pkg::OP_SKIP_SET, b, 7'h22};
      prog.mem[base + 6] = {ise_pkg::OP_XORLIT, 8'hFF};
      prog.mem[base + 7] = {ise_pkg::OP_CALL, 11'h017};
      fwr(7'h20, v);
      fwr(7'h21, u);
      fwr(7'h22, s);
      fwr(7'h23, ~v);
      @(negedge clk_sys);
      spin(11'h010);
      repeat (24) @(negedge clk_sys);
      r = k - a;
      c = k >= a;
      dc = k[3:0] >= a[3:0];
      x = r ^ v;
      w = d0 ? r : x;
      fe = d0 ? x : v;
      rr = {c, u[7:1]};
      c = u[0];
      w = d1 ? w : rr;
      f21 = d1 ? rr : u;
      w = s[b] ? w : ~w;
      z = s[b] ? 1'b1 : (w == 8'h00);
      `CHK(w_reg, w);
      `CHK(flags.carry, c);
      `CHK(flags.digit_carry, dc);
      `CHK(flags.zero, z);
      `CHK(top_of_stack, base + 8);
      frd(7'h20, fe);
      frd(7'h21, f21);
      frd(7'h23, 8'h00);
      // self call loop: every call is followed by one flush cycle
      fl0 = fl;
      @(negedge clk_sys);
      `CHK(fl ^ fl0, 1'b1);
      $display("test %0d done", i);
    end
    do_reset(5'h00);
    prog.mem[16] = ise_pkg::OP_SLEEP;
    repeat (300) @(negedge clk_sys);
    spin(11'h010);
    repeat (10) @(negedge clk_sys);
    `CHK(sleeping, 1'b1);
    `CHK({wdc, wdp}, 16'h0000);
    `CHK({flags.power_down_flag, flags.timeout_flag}, 2'b01);
    wake = 1'b1;
    for (int n = 0; n < 8 && sleeping !== 1'b0; n++)
      @(negedge clk_sys);
    `CHK(sleeping, 1'b0);
    $display("sleep test done");
    print_verdict();
  end
endmodule
